// ===== rtl/array_counter_regs.sv
// Counter, snapshot, compare and mode register access for the counter array
`timescale 1ns/1ps
module array_counter_regs (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Special-function-register bus
	input  wire logic [7:0]  sfr_address,
	input  wire logic        sfr_write,
	input  wire logic        sfr_read,
	input  wire logic [7:0]  sfr_write_data,
	output logic      [7:0]  sfr_read_data,
	output logic             sfr_hit,
	// Control from neighbouring registers
	input  wire logic        watchdog_enable_bit,
	input  wire logic        auto_reload_select,
	input  wire logic [1:0]  cycle_length_field,
	// Counting engine
	input  wire logic        count_tick,
	// Block state
	output logic      [15:0] array_counter,
	output logic      [95:0] compare_value,
	output logic      [95:0] reload_value,
	output logic      [47:0] mode_registers,
	output logic      [5:0]  comparator_enable,
	output logic             cycle_overflow
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0]     counter;
		logic [7:0]      snapshot;
		logic [5:0][7:0] mode;
		logic [7:0]      rdata;
		logic            hit;
		logic            ovf;
		logic            rd_store;
		logic            rd_high;
	} regs_state_t;

	regs_state_t state;
	regs_state_t next_state;

	array_regs_pkg::reg_select_t sel;
	logic [2:0]  idx;
	logic [15:0] cmp_word;
	logic [15:0] rld_word;
	logic        cmp_wl;
	logic        cmp_wh;
	logic        rld_wl;
	logic        rld_wh;
	logic        idx_valid;

	// Overflow bit position for the selected cycle length
	function automatic logic [3:0] overflow_bit(input logic [1:0] field);
		unique case (field)
			array_regs_pkg::CYCLE_8_BITS:  overflow_bit = 4'd7;
			array_regs_pkg::CYCLE_9_BITS:  overflow_bit = 4'd8;
			array_regs_pkg::CYCLE_10_BITS: overflow_bit = 4'd9;
			array_regs_pkg::CYCLE_11_BITS: overflow_bit = 4'd10;
		endcase
	endfunction : overflow_bit

	sfr_decode u_decode (
		.address      (sfr_address),
		.select       (sel),
		.module_index (idx)
	);

	// ---------------------------------------------------------------
	// Compare and reload stores
	// ---------------------------------------------------------------
	assign cmp_wl = sfr_write && sel == array_regs_pkg::SEL_CMP_LOW && !auto_reload_select;
	assign cmp_wh = sfr_write && sel == array_regs_pkg::SEL_CMP_HIGH && !auto_reload_select;
	assign rld_wl = sfr_write && sel == array_regs_pkg::SEL_CMP_LOW && auto_reload_select;
	assign rld_wh = sfr_write && sel == array_regs_pkg::SEL_CMP_HIGH && auto_reload_select;
	assign idx_valid = idx < 3'(array_regs_pkg::NUM_MODULES);

	compare_value_store u_compare (
		.clock       (clock),
		.resetn      (resetn),
		.write_low   (cmp_wl),
		.write_high  (cmp_wh),
		.write_index (idx),
		.write_data  (sfr_write_data),
		.read_index  (idx),
		.read_word   (cmp_word),
		.all_words   (compare_value)
	);

	compare_value_store u_reload (
		.clock       (clock),
		.resetn      (resetn),
		.write_low   (rld_wl),
		.write_high  (rld_wh),
		.write_index (idx),
		.write_data  (sfr_write_data),
		.read_index  (idx),
		.read_word   (rld_word),
		.all_words   (reload_value)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	logic [15:0] next_count;
	logic [3:0]  obit;

	always_comb begin
		next_state = state;
		next_count = state.counter + 16'h0001;
		obit       = overflow_bit(cycle_length_field);
		next_state.hit      = 1'b0;
		next_state.rd_store = 1'b0;
		next_state.rd_high  = 1'b0;
		next_state.rdata    = state.rdata;

		if (count_tick) begin
			next_state.counter = next_count;
			if (state.counter[obit] && !next_count[obit])
				next_state.ovf = 1'b1;
		end

		if (sfr_write && !watchdog_enable_bit) begin
			if (sel == array_regs_pkg::SEL_COUNTER_LOW)
				next_state.counter[7:0] = sfr_write_data;
			if (sel == array_regs_pkg::SEL_COUNTER_HIGH)
				next_state.counter[15:8] = sfr_write_data;
		end

		if (sfr_write && sel == array_regs_pkg::SEL_CMP_LOW && idx_valid)
			next_state.mode[idx][array_regs_pkg::MODE_COMPARATOR_ENABLE_BIT] = 1'b0;
		if (sfr_write && sel == array_regs_pkg::SEL_CMP_HIGH && idx_valid)
			next_state.mode[idx][array_regs_pkg::MODE_COMPARATOR_ENABLE_BIT] = 1'b1;
		if (sfr_write && sel == array_regs_pkg::SEL_MODE && idx_valid &&
			!(idx == 3'(array_regs_pkg::WATCHDOG_MODULE) && watchdog_enable_bit))
			next_state.mode[idx] = sfr_write_data;

		if (sfr_read) begin
			next_state.hit = (sel != array_regs_pkg::SEL_NONE);
			unique case (sel)
				array_regs_pkg::SEL_COUNTER_LOW: begin
					next_state.rdata    = state.counter[7:0];
					next_state.snapshot = state.counter[15:8];
				end
				array_regs_pkg::SEL_COUNTER_HIGH: next_state.rdata = state.snapshot;
				array_regs_pkg::SEL_CMP_LOW:  next_state.rd_store = 1'b1;
				array_regs_pkg::SEL_CMP_HIGH: begin
					next_state.rd_store = 1'b1;
					next_state.rd_high  = 1'b1;
				end
				array_regs_pkg::SEL_MODE: next_state.rdata = idx_valid ? state.mode[idx]
					: array_regs_pkg::BYTE_RESET;
				array_regs_pkg::SEL_NONE: next_state.rdata = array_regs_pkg::BYTE_RESET;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			state <= '0;
		else
			state <= next_state;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic [7:0]  rd_sel_l;
	logic [7:0]  rd_sel_h;
	logic [5:0]  cmp_en;

	// Store lookup lands in the same cycle as the registered byte
	assign rd_sel_l = auto_reload_select ? rld_word[7:0] : cmp_word[7:0];
	assign rd_sel_h = auto_reload_select ? rld_word[15:8] : cmp_word[15:8];
	assign sfr_read_data = !state.rd_store ? state.rdata
		: (state.rd_high ? rd_sel_h : rd_sel_l);
	assign sfr_hit        = state.hit;
	assign array_counter  = state.counter;
	assign mode_registers = state.mode;
	assign cycle_overflow = state.ovf;

	always_comb begin
		for (int m = 0; m < array_regs_pkg::NUM_MODULES; m++)
			cmp_en[m] = state.mode[m][array_regs_pkg::MODE_COMPARATOR_ENABLE_BIT];
	end
	assign comparator_enable = cmp_en;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_low_read;
		sfr_read && sel == array_regs_pkg::SEL_COUNTER_LOW;
	endsequence

	a_snapshot_on_low: assert property (@(posedge clock) disable iff (!resetn)
		s_low_read |=> state.snapshot == $past(state.counter[15:8]))
		else $error("snapshot not loaded on low read");
	a_snapshot_hold: assert property (@(posedge clock) disable iff (!resetn)
		resetn && !(sfr_read && sel == array_regs_pkg::SEL_COUNTER_LOW) |=> $stable(state.snapshot))
		else $error("snapshot changed without low read");
	a_lock_counter_low: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && watchdog_enable_bit && sel == array_regs_pkg::SEL_COUNTER_LOW && !count_tick
		|=> $stable(state.counter))
		else $error("counter low written under watchdog");
	a_lock_counter_high: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && watchdog_enable_bit && sel == array_regs_pkg::SEL_COUNTER_HIGH && !count_tick
		|=> $stable(state.counter))
		else $error("counter high written under watchdog");
	a_low_clears_en: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && sel == array_regs_pkg::SEL_CMP_LOW |=> !comparator_enable[$past(idx)])
		else $error("compare low write did not clear enable");
	a_high_sets_en: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && sel == array_regs_pkg::SEL_CMP_HIGH |=> comparator_enable[$past(idx)])
		else $error("compare high write did not set enable");
	a_mode5_locked: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && watchdog_enable_bit && sfr_address == array_regs_pkg::ADDR_MODE_M5
		|=> $stable(state.mode[5]))
		else $error("module five mode changed under watchdog");
	a_counter_write: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !watchdog_enable_bit && !count_tick && sel == array_regs_pkg::SEL_COUNTER_LOW
		|=> array_counter[7:0] == $past(sfr_write_data))
		else $error("counter low write lost");
	a_reload_steer: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && auto_reload_select && sel == array_regs_pkg::SEL_CMP_LOW
		|=> $stable(compare_value))
		else $error("reload write reached compare value");

	// ---------------------------------------------------------------
	// Read path checks
	// ---------------------------------------------------------------
	sequence s_high_read;
		sfr_read && sel == array_regs_pkg::SEL_COUNTER_HIGH;
	endsequence

	// Low read, one idle cycle, then high read
	sequence s_coherent_pair;
		(sfr_read && sel == array_regs_pkg::SEL_COUNTER_LOW) ##1 !sfr_read
		##1 (sfr_read && sel == array_regs_pkg::SEL_COUNTER_HIGH);
	endsequence

	sequence s_reload_low_read;
		(sfr_read && auto_reload_select && sfr_address == array_regs_pkg::ADDR_CMP_LOW_M2)
		##1 auto_reload_select;
	endsequence

	a_low_read_data: assert property (@(posedge clock) disable iff (!resetn)
		s_low_read |=> sfr_hit && sfr_read_data == $past(state.counter[7:0]))
		else $error("counter low read returned wrong byte");
	a_high_reads_snap: assert property (@(posedge clock) disable iff (!resetn)
		s_high_read |=> sfr_hit && sfr_read_data == $past(state.snapshot))
		else $error("counter high read bypassed snapshot");
	a_coherent_pair: assert property (@(posedge clock) disable iff (!resetn)
		s_coherent_pair |=> sfr_read_data == $past(state.counter[15:8], 3))
		else $error("counter byte pair not coherent");
	a_reload_read: assert property (@(posedge clock) disable iff (!resetn)
		s_reload_low_read |-> sfr_read_data == reload_value[39:32])
		else $error("reload low byte not returned");

	// ---------------------------------------------------------------
	// Write path checks
	// ---------------------------------------------------------------
	a_counter_high_write: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !watchdog_enable_bit && sel == array_regs_pkg::SEL_COUNTER_HIGH
		|=> array_counter[15:8] == $past(sfr_write_data))
		else $error("counter high write lost");
	a_cmp_low_m0: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !auto_reload_select && sfr_address == array_regs_pkg::ADDR_CMP_LOW_M0
		|=> compare_value[7:0] == $past(sfr_write_data))
		else $error("compare low byte write lost");
	a_cmp_high_m0: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !auto_reload_select && sfr_address == array_regs_pkg::ADDR_CMP_HIGH_M0
		|=> compare_value[15:8] == $past(sfr_write_data))
		else $error("compare high byte write lost");
	a_compare_steer: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !auto_reload_select && sel == array_regs_pkg::SEL_CMP_HIGH
		|=> $stable(reload_value))
		else $error("compare write reached reload value");
	a_mode5_write: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && !watchdog_enable_bit && sfr_address == array_regs_pkg::ADDR_MODE_M5
		|=> mode_registers[47:40] == $past(sfr_write_data))
		else $error("module five mode write lost");
	a_mode_drives_en: assert property (@(posedge clock) disable iff (!resetn)
		sfr_write && sfr_address == array_regs_pkg::ADDR_MODE_M4
		|=> comparator_enable[4]
			== $past(sfr_write_data[array_regs_pkg::MODE_COMPARATOR_ENABLE_BIT]))
		else $error("comparator enable does not follow mode bit");

	// ---------------------------------------------------------------
	// Overflow checks
	// ---------------------------------------------------------------
	a_overflow_sticky: assert property (@(posedge clock) disable iff (!resetn)
		resetn && cycle_overflow |=> cycle_overflow)
		else $error("overflow flag dropped");
	a_overflow_quiet: assert property (@(posedge clock) disable iff (!resetn)
		resetn && !cycle_overflow && !count_tick |=> !cycle_overflow)
		else $error("overflow set without a count");
	a_wrap_8_bits: assert property (@(posedge clock) disable iff (!resetn)
		count_tick && cycle_length_field == array_regs_pkg::CYCLE_8_BITS
		&& array_counter[7:0] == 8'hff |=> cycle_overflow)
		else $error("eight bit wrap not flagged");
	a_wrap_11_bits: assert property (@(posedge clock) disable iff (!resetn)
		count_tick && cycle_length_field == array_regs_pkg::CYCLE_11_BITS
		&& array_counter[10:0] == 11'h7ff |=> cycle_overflow)
		else $error("eleven bit wrap not flagged");

endmodule : array_counter_regs

// ===== rtl/array_regs_pkg.sv
// Constants and types for the counter array register block
package array_regs_pkg;

	localparam int          NUM_MODULES   = 6;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_COUNTER_LOW  = 8'hf9;
	localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
	localparam logic [7:0] ADDR_CMP_LOW_M0   = 8'hfb;
	localparam logic [7:0] ADDR_CMP_HIGH_M0  = 8'hfc;
	localparam logic [7:0] ADDR_CMP_LOW_M1   = 8'he9;
	localparam logic [7:0] ADDR_CMP_HIGH_M1  = 8'hea;
	localparam logic [7:0] ADDR_CMP_LOW_M2   = 8'heb;
	localparam logic [7:0] ADDR_CMP_HIGH_M2  = 8'hec;
	localparam logic [7:0] ADDR_CMP_LOW_M3   = 8'hed;
	localparam logic [7:0] ADDR_CMP_HIGH_M3  = 8'hee;
	localparam logic [7:0] ADDR_CMP_LOW_M4   = 8'hfd;
	localparam logic [7:0] ADDR_CMP_HIGH_M4  = 8'hfe;
	localparam logic [7:0] ADDR_CMP_LOW_M5   = 8'hd2;
	localparam logic [7:0] ADDR_CMP_HIGH_M5  = 8'hd3;
	localparam logic [7:0] ADDR_MODE_M0      = 8'hda;
	localparam logic [7:0] ADDR_MODE_M1      = 8'hdb;
	localparam logic [7:0] ADDR_MODE_M2      = 8'hdc;
	localparam logic [7:0] ADDR_MODE_M3      = 8'hdd;
	localparam logic [7:0] ADDR_MODE_M4      = 8'hde;
	localparam logic [7:0] ADDR_MODE_M5      = 8'hce;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MODE_COMPARATOR_ENABLE_BIT = 6;
	localparam int LOW_BYTE_LSB               = 0;
	localparam int HIGH_BYTE_LSB              = 8;
	localparam int WATCHDOG_MODULE            = 5;

	// Cycle length field codes
	localparam logic [1:0] CYCLE_8_BITS  = 2'h0;
	localparam logic [1:0] CYCLE_9_BITS  = 2'h1;
	localparam logic [1:0] CYCLE_10_BITS = 2'h2;
	localparam logic [1:0] CYCLE_11_BITS = 2'h3;

	// Register decode result
	typedef enum logic [2:0] {
		SEL_NONE         = 3'b000,
		SEL_COUNTER_LOW  = 3'b001,
		SEL_COUNTER_HIGH = 3'b010,
		SEL_CMP_LOW      = 3'b011,
		SEL_CMP_HIGH     = 3'b100,
		SEL_MODE         = 3'b101
	} reg_select_t;

endpackage : array_regs_pkg

// ===== rtl/compare_value_store.sv
// Six-entry byte-lane store for compare or reload values, registered read
`timescale 1ns/1ps
module compare_value_store (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Write port
	input  wire logic        write_low,
	input  wire logic        write_high,
	input  wire logic [2:0]  write_index,
	input  wire logic [7:0]  write_data,
	// Read port
	input  wire logic [2:0]  read_index,
	output logic      [15:0] read_word,
	// Whole contents
	output logic      [95:0] all_words
);

	typedef struct packed {
		logic [5:0][15:0] word;
		logic [15:0]      rd;
	} store_state_t;

	store_state_t state;
	store_state_t next_state;

	always_comb begin
		next_state = state;
		if (write_index < 3'(array_regs_pkg::NUM_MODULES)) begin
			if (write_low)
				next_state.word[write_index][7:0] = write_data;
			if (write_high)
				next_state.word[write_index][15:8] = write_data;
		end
		if (read_index < 3'(array_regs_pkg::NUM_MODULES))
			next_state.rd = state.word[read_index];
		else
			next_state.rd = array_regs_pkg::WORD_RESET;
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign read_word = state.rd;
	assign all_words = state.word;

endmodule : compare_value_store

// ===== rtl/sfr_decode.sv
// Address decode of the counter array special-function registers
`timescale 1ns/1ps
module sfr_decode (
	// Address in
	input  wire logic                        [7:0] address,
	// Decode out
	output array_regs_pkg::reg_select_t           select,
	output logic                             [2:0] module_index
);

	always_comb begin
		select       = array_regs_pkg::SEL_NONE;
		module_index = 3'd0;
		unique case (address)
			array_regs_pkg::ADDR_COUNTER_LOW:  select = array_regs_pkg::SEL_COUNTER_LOW;
			array_regs_pkg::ADDR_COUNTER_HIGH: select = array_regs_pkg::SEL_COUNTER_HIGH;
			array_regs_pkg::ADDR_CMP_LOW_M0: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd0; end
			array_regs_pkg::ADDR_CMP_LOW_M1: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd1; end
			array_regs_pkg::ADDR_CMP_LOW_M2: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd2; end
			array_regs_pkg::ADDR_CMP_LOW_M3: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd3; end
			array_regs_pkg::ADDR_CMP_LOW_M4: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd4; end
			array_regs_pkg::ADDR_CMP_LOW_M5: begin select = array_regs_pkg::SEL_CMP_LOW; module_index = 3'd5; end
			array_regs_pkg::ADDR_CMP_HIGH_M0: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd0; end
			array_regs_pkg::ADDR_CMP_HIGH_M1: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd1; end
			array_regs_pkg::ADDR_CMP_HIGH_M2: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd2; end
			array_regs_pkg::ADDR_CMP_HIGH_M3: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd3; end
			array_regs_pkg::ADDR_CMP_HIGH_M4: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd4; end
			array_regs_pkg::ADDR_CMP_HIGH_M5: begin select = array_regs_pkg::SEL_CMP_HIGH; module_index = 3'd5; end
			array_regs_pkg::ADDR_MODE_M0: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd0; end
			array_regs_pkg::ADDR_MODE_M1: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd1; end
			array_regs_pkg::ADDR_MODE_M2: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd2; end
			array_regs_pkg::ADDR_MODE_M3: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd3; end
			array_regs_pkg::ADDR_MODE_M4: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd4; end
			array_regs_pkg::ADDR_MODE_M5: begin select = array_regs_pkg::SEL_MODE; module_index = 3'd5; end
			default: select = array_regs_pkg::SEL_NONE;
		endcase
	end

endmodule : sfr_decode

// ===== sim/testbench.sv
// Self-checking bench for the counter array register block
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
	$display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clock;
	logic        resetn;
	logic [7:0]  sfr_address;
	logic        sfr_write;
	logic        sfr_read;
	logic [7:0]  sfr_write_data;
	logic [7:0]  sfr_read_data;
	logic        sfr_hit;
	logic        watchdog_enable_bit;
	logic        auto_reload_select;
	logic [1:0]  cycle_length_field;
	logic        count_tick;
	logic [15:0] array_counter;
	logic [95:0] compare_value;
	logic [95:0] reload_value;
	logic [47:0] mode_registers;
	logic [5:0]  comparator_enable;
	logic        cycle_overflow;
	logic [7:0]  rdata;
	logic        rhit;
	int          fail_count;
	int          checks_done;
	typedef struct packed {
		logic [7:0] low_addr;
		logic [7:0] high_addr;
		logic [7:0] low_data;
		logic [7:0] high_data;
	} row_t;
	row_t rows [0:5] = '{
		'{array_regs_pkg::ADDR_CMP_LOW_M0, array_regs_pkg::ADDR_CMP_HIGH_M0, 8'h10, 8'hf0},
		'{array_regs_pkg::ADDR_CMP_LOW_M1, array_regs_pkg::ADDR_CMP_HIGH_M1, 8'h21, 8'he1},
		'{array_regs_pkg::ADDR_CMP_LOW_M2, array_regs_pkg::ADDR_CMP_HIGH_M2, 8'h32, 8'hd2},
		'{array_regs_pkg::ADDR_CMP_LOW_M3, array_regs_pkg::ADDR_CMP_HIGH_M3, 8'h43, 8'hc3},
		'{array_regs_pkg::ADDR_CMP_LOW_M4, array_regs_pkg::ADDR_CMP_HIGH_M4, 8'h54, 8'hb4},
		'{array_regs_pkg::ADDR_CMP_LOW_M5, array_regs_pkg::ADDR_CMP_HIGH_M5, 8'h65, 8'ha5}
	};

	array_counter_regs dut (
		.clock(clock), .resetn(resetn), .sfr_address(sfr_address), .sfr_write(sfr_write),
		.sfr_read(sfr_read), .sfr_write_data(sfr_write_data), .sfr_read_data(sfr_read_data),
		.sfr_hit(sfr_hit), .watchdog_enable_bit(watchdog_enable_bit),
		.auto_reload_select(auto_reload_select), .cycle_length_field(cycle_length_field),
		.count_tick(count_tick), .array_counter(array_counter), .compare_value(compare_value),
		.reload_value(reload_value), .mode_registers(mode_registers),
		.comparator_enable(comparator_enable), .cycle_overflow(cycle_overflow)
	);

	always #2.5 clock = ~clock;

	// ---------------------------------------------------------------
	// Bus and stimulus tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_address <= a;
		sfr_write_data <= d;
		sfr_write <= 1'b1;
		@(posedge clock);
		sfr_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge clock);
		sfr_address <= a;
		sfr_read <= 1'b1;
		@(posedge clock);
		sfr_read <= 1'b0;
		#1;
		d = sfr_read_data;
		h = sfr_hit;
	endtask : rd

	task automatic tick(input int k);
		@(posedge clock);
		count_tick <= 1'b1;
		repeat (k) @(posedge clock);
		count_tick <= 1'b0;
		#1;
	endtask : tick

	task automatic do_reset();
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		resetn <= 1'b1;
		#1;
	endtask : do_reset

	task automatic give_verdict();
		$display("Comparisons: %0d, mismatches: %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// ---------------------------------------------------------------
	// Watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		give_verdict();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		sfr_address = 8'h00;
		sfr_write = 1'b0;
		sfr_read = 1'b0;
		sfr_write_data = 8'h00;
		watchdog_enable_bit = 1'b0;
		auto_reload_select = 1'b0;
		cycle_length_field = 2'h0;
		count_tick = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		#1;
		`CHECK_EQ(array_counter, 16'h0000)
		`CHECK_EQ(compare_value, 96'h0)
		`CHECK_EQ(comparator_enable, 6'h00)
		$display("Test reset_values done");
		for (int m = 0; m < 6; m++) begin
			wr(rows[m].high_addr, rows[m].high_data);
			`CHECK_EQ(comparator_enable[m], 1'b1)
			`CHECK_EQ(mode_registers[8*m+6], 1'b1)
			wr(rows[m].low_addr, rows[m].low_data);
			`CHECK_EQ(comparator_enable[m], 1'b0)
			`CHECK_EQ(compare_value[16*m+:16], {rows[m].high_data, rows[m].low_data})
			rd(rows[m].low_addr, rdata, rhit);
			`CHECK_EQ({rhit, rdata}, {1'b1, rows[m].low_data})
			rd(rows[m].high_addr, rdata, rhit);
			`CHECK_EQ(rdata, rows[m].high_data)
		end
		$display("Test compare_rows done");
		@(posedge clock);
		auto_reload_select <= 1'b1;
		wr(array_regs_pkg::ADDR_CMP_LOW_M2, 8'h5a);
		wr(array_regs_pkg::ADDR_CMP_HIGH_M2, 8'h3c);
		`CHECK_EQ(reload_value[47:32], 16'h3c5a)
		`CHECK_EQ(compare_value[47:32], 16'hd232)
		rd(array_regs_pkg::ADDR_CMP_LOW_M2, rdata, rhit);
		`CHECK_EQ(rdata, 8'h5a)
		@(posedge clock);
		auto_reload_select <= 1'b0;
		rd(array_regs_pkg::ADDR_CMP_HIGH_M2, rdata, rhit);
		`CHECK_EQ(rdata, 8'hd2)
		$display("Test auto_reload done");
		wr(array_regs_pkg::ADDR_COUNTER_LOW, 8'hfe);
		wr(array_regs_pkg::ADDR_COUNTER_HIGH, 8'h12);
		`CHECK_EQ(array_counter, 16'h12fe)
		rd(array_regs_pkg::ADDR_COUNTER_LOW, rdata, rhit);
		`CHECK_EQ({rhit, rdata}, {1'b1, 8'hfe})
		tick(4);
		`CHECK_EQ(array_counter, 16'h1302)
		rd(array_regs_pkg::ADDR_COUNTER_HIGH, rdata, rhit);
		`CHECK_EQ(rdata, 8'h12)
		rd(array_regs_pkg::ADDR_COUNTER_LOW, rdata, rhit);
		`CHECK_EQ(rdata, 8'h02)
		rd(array_regs_pkg::ADDR_COUNTER_HIGH, rdata, rhit);
		`CHECK_EQ(rdata, 8'h13)
		$display("Test counter_snapshot done");
		@(posedge clock);
		watchdog_enable_bit <= 1'b1;
		wr(array_regs_pkg::ADDR_COUNTER_LOW, 8'h00);
		`CHECK_EQ(array_counter, 16'h1302)
		wr(array_regs_pkg::ADDR_COUNTER_HIGH, 8'h00);
		`CHECK_EQ(array_counter, 16'h1302)
		wr(array_regs_pkg::ADDR_MODE_M5, 8'h40);
		`CHECK_EQ(mode_registers[47:40], 8'h00)
		wr(array_regs_pkg::ADDR_MODE_M4, 8'h40);
		`CHECK_EQ(comparator_enable[4], 1'b1)
		@(posedge clock);
		watchdog_enable_bit <= 1'b0;
		wr(array_regs_pkg::ADDR_MODE_M5, 8'h40);
		`CHECK_EQ(comparator_enable[5], 1'b1)
		rd(array_regs_pkg::ADDR_MODE_M5, rdata, rhit);
		`CHECK_EQ(rdata, 8'h40)
		wr(array_regs_pkg::ADDR_COUNTER_HIGH, 8'h77);
		`CHECK_EQ(array_counter, 16'h7702)
		rd(8'h00, rdata, rhit);
		`CHECK_EQ({rhit, rdata}, {1'b0, 8'h00})
		$display("Test watchdog_lock done");
		for (int f = 0; f < 4; f++) begin
			@(posedge clock);
			cycle_length_field <= 2'(f);
			do_reset();
			wr(array_regs_pkg::ADDR_COUNTER_LOW, 8'hfe);
			tick((1 << (8 + f)) - 255);
			`CHECK_EQ(cycle_overflow, 1'b0)
			tick(1);
			`CHECK_EQ(cycle_overflow, 1'b1)
		end
		$display("Test cycle_length done");
		give_verdict();
	end
endmodule : testbench
